// File: hw/accel_output_data_regs.sv
// output data registers of a three-axis acceleration sensor: conversion
// sequencing, simultaneous publish with the data-ready flag, read mux,
// and the result fifo in front of the staging registers
// assumes the serial interface decodes reads into a start/next strobe pair
// and that all inputs come from logic on i_core_clk

////////////////////////////////////////////////////////////////////////////////

// Contract
// - temperature is 8-bit signed, zero near 25C
// - temperature refreshed every output data cycle
// - magnitude updated only while magnitude_enable set
// - magnitude register reads clear data_ready_flag
// - magnitude byte order follows byte_order_select
// - magnitude low byte 02h, high nibble 03h
// - twelve-bit signed axes in 04h to 09h
// - axes latched together with data_ready_flag set
// - fast read skips upper bytes in bursts
// - fast read puts axis upper bits at lower address
// - little endian: low byte first, nibble right
// - little endian axis upper byte sign extended
// - big endian: bits 11..4 first, nibble left
// - axis byte order selectable, little endian default
// - temperature then x, y, z, 40us apart
// - axis register reads clear data_ready_flag
// - big endian second register low nibble zero
module accel_output_data_regs #(
	parameter int CONV_GAP_CYCLES = accel_out_pkg::CONV_GAP_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_odr_tick,
	input wire logic i_magnitude_enable,
	input wire logic i_byte_order_select,
	input wire logic i_fast_read,
	output logic o_conv_req,
	output logic [1:0] o_conv_chan,
	input wire logic i_conv_valid,
	output logic o_conv_ready,
	input wire logic [1:0] i_conv_chan,
	input wire logic [11:0] i_conv_data,
	input wire logic [11:0] i_vector_magnitude,
	input wire logic i_rd_en,
	input wire logic i_rd_first,
	input wire logic [7:0] i_rd_addr,
	input wire logic i_burst_active,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic [7:0] o_rd_addr,
	output logic o_data_ready_flag
);
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT} seq_state_t;

	seq_state_t seq_state;
	logic [accel_out_pkg::GAP_CNT_W-1:0] gap_cnt;
	logic [1:0] seq_chan;

	logic fifo_valid;
	logic fifo_ready;
	logic [accel_out_pkg::FIFO_WIDTH-1:0] fifo_data;
	logic [1:0] drain_chan;
	logic [11:0] drain_data;

	logic [7:0] temp_stage;
	logic [11:0] x_stage;
	logic [11:0] y_stage;
	logic [11:0] z_stage;
	logic publish_pending;
	logic publish;

	logic [7:0] temperature_value;
	logic [11:0] vector_magnitude;
	logic [11:0] x_sample;
	logic [11:0] y_sample;
	logic [11:0] z_sample;

	logic [7:0] rd_ptr;
	logic [7:0] cur_addr;
	logic [7:0] next_rd_data;
	logic [7:0] next_addr;
	logic flag_clear;

	////////////////////////////////////////////////////////////////////////////////
	// conversion sequencer

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seq_state <= SEQ_IDLE;
			gap_cnt <= '0;
			seq_chan <= accel_out_pkg::CHAN_TEMPERATURE;
			o_conv_req <= 1'b0;
			o_conv_chan <= accel_out_pkg::CHAN_TEMPERATURE;
		end else begin
			o_conv_req <= 1'b0;
			unique case (seq_state)
				SEQ_IDLE: begin
					if (i_odr_tick) begin
						// temperature first, then the axes
						o_conv_req <= 1'b1;
						o_conv_chan <= accel_out_pkg::CHAN_TEMPERATURE;
						seq_chan <= accel_out_pkg::CHAN_TEMPERATURE;
						gap_cnt <= '0;
						seq_state <= SEQ_WAIT;
					end
				end
				SEQ_WAIT: begin
					if (gap_cnt == accel_out_pkg::GAP_CNT_W'(CONV_GAP_CYCLES - 1)) begin
						gap_cnt <= '0;
						if (seq_chan == accel_out_pkg::CHAN_Z) begin
							seq_state <= SEQ_IDLE;
						end else begin
							o_conv_req <= 1'b1;
							o_conv_chan <= seq_chan + 2'h1;
							seq_chan <= seq_chan + 2'h1;
						end
					end else begin
						gap_cnt <= gap_cnt + 1'b1;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// result buffering and staging

	sample_fifo #(
		.WIDTH(accel_out_pkg::FIFO_WIDTH),
		.DEPTH(accel_out_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_arst_n(i_arst_n),
		.i_in_valid(i_conv_valid),
		.o_in_ready(o_conv_ready),
		.i_in_data({i_conv_chan, i_conv_data}),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_ready),
		.o_out_data(fifo_data)
	);

	assign drain_chan = fifo_data[accel_out_pkg::FIFO_WIDTH-1 -: 2];
	assign drain_data = fifo_data[11:0];
	// stall the drain while a full set waits, so stages keep one coherent set
	assign fifo_ready = !publish_pending;
	// hold the visible set back until any burst read has ended
	assign publish = publish_pending && !i_burst_active;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			temp_stage <= accel_out_pkg::TEMPERATURE_RESET;
			x_stage <= accel_out_pkg::SAMPLE_RESET;
			y_stage <= accel_out_pkg::SAMPLE_RESET;
			z_stage <= accel_out_pkg::SAMPLE_RESET;
			publish_pending <= 1'b0;
		end else begin
			if (publish) begin
				publish_pending <= 1'b0;
			end
			if (fifo_valid && fifo_ready) begin
				unique case (drain_chan)
					accel_out_pkg::CHAN_TEMPERATURE: temp_stage <= drain_data[7:0];
					accel_out_pkg::CHAN_X: x_stage <= drain_data;
					accel_out_pkg::CHAN_Y: y_stage <= drain_data;
					accel_out_pkg::CHAN_Z: begin
						z_stage <= drain_data;
						publish_pending <= 1'b1;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// published output set

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			temperature_value <= accel_out_pkg::TEMPERATURE_RESET;
			x_sample <= accel_out_pkg::SAMPLE_RESET;
			y_sample <= accel_out_pkg::SAMPLE_RESET;
			z_sample <= accel_out_pkg::SAMPLE_RESET;
		end else if (publish) begin
			temperature_value <= temp_stage;
			x_sample <= x_stage;
			y_sample <= y_stage;
			z_sample <= z_stage;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			vector_magnitude <= accel_out_pkg::MAGNITUDE_RESET;
		end else if (publish && i_magnitude_enable) begin
			vector_magnitude <= i_vector_magnitude;
		end
	end

	// a new set wins over a clearing read in the same cycle
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_data_ready_flag <= 1'b0;
		end else if (publish) begin
			o_data_ready_flag <= 1'b1;
		end else if (flag_clear) begin
			o_data_ready_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read path

	assign cur_addr = i_rd_first ? i_rd_addr : rd_ptr;
	assign flag_clear = i_rd_en && (cur_addr >= accel_out_pkg::ADDR_VECTOR_MAGNITUDE_LOW)
		&& (cur_addr <= accel_out_pkg::ADDR_Z_AXIS_HIGH_BYTE);

	always_comb begin
		next_addr = cur_addr + accel_out_pkg::ADDR_STEP;
		// fast read steps from one axis lower address to the next
		if (i_fast_read && (cur_addr >= accel_out_pkg::ADDR_X_AXIS_LOW_BYTE)
			&& (cur_addr <= accel_out_pkg::ADDR_Z_AXIS_LOW_BYTE) && !cur_addr[0]) begin
			next_addr = cur_addr + accel_out_pkg::ADDR_FAST_STEP;
		end
	end

	function automatic logic [7:0] axis_byte(input logic [11:0] s, input logic upper,
			input logic big);
		logic [7:0] b;
		b = 8'h00;
		if (big) begin
			b = upper ? {s[3:0], accel_out_pkg::NIBBLE_ZERO} : s[11:4];
		end else begin
			b = upper ? {{4{s[11]}}, s[11:8]} : s[7:0];
		end
		return b;
	endfunction : axis_byte

	always_comb begin
		logic big;
		big = i_byte_order_select || i_fast_read;
		unique case (cur_addr)
			accel_out_pkg::ADDR_TEMPERATURE_VALUE: next_rd_data = temperature_value;
			accel_out_pkg::ADDR_VECTOR_MAGNITUDE_LOW: next_rd_data = i_byte_order_select ?
				vector_magnitude[11:4] : vector_magnitude[7:0];
			accel_out_pkg::ADDR_VECTOR_MAGNITUDE_HIGH: next_rd_data = i_byte_order_select ?
				{vector_magnitude[3:0], accel_out_pkg::NIBBLE_ZERO} :
				{accel_out_pkg::NIBBLE_ZERO, vector_magnitude[11:8]};
			accel_out_pkg::ADDR_X_AXIS_LOW_BYTE: next_rd_data = axis_byte(x_sample, 1'b0, big);
			accel_out_pkg::ADDR_X_AXIS_HIGH_BYTE: next_rd_data = axis_byte(x_sample, 1'b1, big);
			accel_out_pkg::ADDR_Y_AXIS_LOW_BYTE: next_rd_data = axis_byte(y_sample, 1'b0, big);
			accel_out_pkg::ADDR_Y_AXIS_HIGH_BYTE: next_rd_data = axis_byte(y_sample, 1'b1, big);
			accel_out_pkg::ADDR_Z_AXIS_LOW_BYTE: next_rd_data = axis_byte(z_sample, 1'b0, big);
			accel_out_pkg::ADDR_Z_AXIS_HIGH_BYTE: next_rd_data = axis_byte(z_sample, 1'b1, big);
			default: next_rd_data = accel_out_pkg::UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_ptr <= 8'h00;
			o_rd_valid <= 1'b0;
			o_rd_data <= 8'h00;
			o_rd_addr <= 8'h00;
		end else begin
			o_rd_valid <= i_rd_en;
			if (i_rd_en) begin
				rd_ptr <= next_addr;
				o_rd_data <= next_rd_data;
				o_rd_addr <= cur_addr;
			end
		end
	end
endmodule : accel_output_data_regs

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo for converter results, width and depth as parameters
// one clock only; depth must be a power of two

module sample_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
) (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;

	assign o_in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign o_out_valid = (wr_ptr != rd_ptr);
	assign o_out_data = mem[rd_ptr[AW-1:0]];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule : sample_fifo

// File: hw/accel_out_pkg.sv
// constants shared by the accelerometer output data register block
// assumes an 8-bit register address space and 12-bit converter results
package accel_out_pkg;
	localparam int ADDR_W = 8;
	localparam int SAMPLE_W = 12;
	localparam int CHAN_W = 2;
	localparam int FIFO_WIDTH = CHAN_W + SAMPLE_W;
	localparam int FIFO_DEPTH = 16;

	// register map
	localparam logic [7:0] ADDR_TEMPERATURE_VALUE = 8'h01;
	localparam logic [7:0] ADDR_VECTOR_MAGNITUDE_LOW = 8'h02;
	localparam logic [7:0] ADDR_VECTOR_MAGNITUDE_HIGH = 8'h03;
	localparam logic [7:0] ADDR_X_AXIS_LOW_BYTE = 8'h04;
	localparam logic [7:0] ADDR_X_AXIS_HIGH_BYTE = 8'h05;
	localparam logic [7:0] ADDR_Y_AXIS_LOW_BYTE = 8'h06;
	localparam logic [7:0] ADDR_Y_AXIS_HIGH_BYTE = 8'h07;
	localparam logic [7:0] ADDR_Z_AXIS_LOW_BYTE = 8'h08;
	localparam logic [7:0] ADDR_Z_AXIS_HIGH_BYTE = 8'h09;
	localparam logic [7:0] ADDR_STEP = 8'h01;
	localparam logic [7:0] ADDR_FAST_STEP = 8'h02;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// reset values
	localparam logic [7:0] TEMPERATURE_RESET = 8'h00;
	localparam logic [11:0] MAGNITUDE_RESET = 12'h000;
	localparam logic [11:0] SAMPLE_RESET = 12'h000;
	localparam logic [3:0] NIBBLE_ZERO = 4'h0;

	// conversion channels, in acquisition order
	localparam logic [1:0] CHAN_TEMPERATURE = 2'h0;
	localparam logic [1:0] CHAN_X = 2'h1;
	localparam logic [1:0] CHAN_Y = 2'h2;
	localparam logic [1:0] CHAN_Z = 2'h3;

	// timing
	localparam int CORE_CLK_MHZ = 125;
	localparam int CONV_GAP_US = 40;
	localparam int CONV_GAP_CYCLES = CONV_GAP_US * CORE_CLK_MHZ;
	localparam int GAP_CNT_W = 16;
endpackage : accel_out_pkg

// File: hw/sample_fifo.sv
// no logic here: the result fifo module is defined with the register block
// assumes hw/accel_output_data_regs.sv is part of every build

// File: testbench/accel_out_checker.sv
// port assertions for the output data register block
// assumes one clock domain and an asynchronous active-low reset
module accel_out_checker #(
	parameter int CONV_GAP_CYCLES = 8
) (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_byte_order_select,
	input wire logic i_fast_read,
	input wire logic i_rd_en,
	input wire logic i_rd_first,
	input wire logic [7:0] i_rd_addr,
	input wire logic i_burst_active,
	input wire logic o_conv_req,
	input wire logic [1:0] o_conv_chan,
	input wire logic o_rd_valid,
	input wire logic [7:0] o_rd_data,
	input wire logic [7:0] o_rd_addr,
	input wire logic o_data_ready_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_fast_pair;
		o_rd_valid && o_rd_addr inside {8'h04, 8'h06} && $past(i_fast_read)
			##1 i_rd_en && !i_rd_first;
	endsequence
	property p_rd_addr;
		i_rd_en && i_rd_first |=> o_rd_valid && o_rd_addr == $past(i_rd_addr);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read address not echoed");
	property p_unmapped;
		o_rd_valid && (o_rd_addr == 8'h00 || o_rd_addr > 8'h09) |-> o_rd_data == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_clear;
		i_rd_en && i_rd_first && i_burst_active && i_rd_addr inside {[8'h02:8'h09]}
			|=> !o_data_ready_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared by read");
	property p_burst_hold;
		$rose(o_data_ready_flag) |-> !$past(i_burst_active);
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("publish inside burst");
	property p_le_sign;
		o_rd_valid && o_rd_addr inside {8'h05, 8'h07, 8'h09} && !$past(i_byte_order_select)
			&& !$past(i_fast_read) |-> o_rd_data[7:4] == {4{o_rd_data[3]}};
	endproperty
	a_le_sign: assert property (p_le_sign) else $error("upper byte not sign copied");
	property p_be_zero;
		o_rd_valid && o_rd_addr inside {8'h05, 8'h07, 8'h09} && $past(i_byte_order_select)
			|-> o_rd_data[3:0] == 4'h0;
	endproperty
	a_be_zero: assert property (p_be_zero) else $error("low nibble not zero");
	property p_conv_seq;
		o_conv_req && o_conv_chan == 2'h0 |-> ##CONV_GAP_CYCLES o_conv_req && o_conv_chan == 2'h1;
	endproperty
	a_conv_seq: assert property (p_conv_seq) else $error("x request not spaced");
	property p_fast_step;
		s_fast_pair |=> o_rd_addr == $past(o_rd_addr) + 8'h02;
	endproperty
	a_fast_step: assert property (p_fast_step) else $error("fast read did not skip");
endmodule : accel_out_checker
bind accel_output_data_regs accel_out_checker #(.CONV_GAP_CYCLES(CONV_GAP_CYCLES)) u_chk (
	.i_core_clk(i_core_clk),
	.i_arst_n(i_arst_n),
	.i_byte_order_select(i_byte_order_select),
	.i_fast_read(i_fast_read),
	.i_rd_en(i_rd_en),
	.i_rd_first(i_rd_first),
	.i_rd_addr(i_rd_addr),
	.i_burst_active(i_burst_active),
	.o_conv_req(o_conv_req),
	.o_conv_chan(o_conv_chan),
	.o_rd_valid(o_rd_valid),
	.o_rd_data(o_rd_data),
	.o_rd_addr(o_rd_addr),
	.o_data_ready_flag(o_data_ready_flag)
);

// File: testbench/conv_model.sv
// behavioural converter answering the block's conversion requests
// assumes i_set holds temp, x, y, z results, 12 bits each by channel
module conv_model (
	input wire logic i_core_clk,
	input wire logic i_conv_req,
	input wire logic [1:0] i_conv_chan,
	input wire logic i_conv_ready,
	input wire logic [47:0] i_set,
	input wire logic i_slow,
	input wire logic i_flood,
	output logic o_valid,
	output logic [1:0] o_chan,
	output logic [11:0] o_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ch;
	int n;
	initial begin
		o_valid = 1'b0;
		o_chan = 2'h0;
		o_data = 12'h5a5;
		forever begin
			@(posedge i_core_clk);
			if (i_flood) begin
				// unrequested x words, only to fill the fifo
				o_valid <= 1'b1;
				o_chan <= 2'h1;
				o_data <= o_data + {11'h000, i_conv_ready};
			end else if (i_conv_req) begin
				ch = i_conv_chan;
				repeat (i_slow ? 4 : 1) @(posedge i_core_clk);
				o_valid <= 1'b1;
				o_chan <= ch;
				o_data <= i_set[ch*12 +: 12];
				// bounded: a word lost here ends as a flag timeout in the bench
				n = 0;
				do begin
					@(posedge i_core_clk);
					n++;
				end while (!i_conv_ready && n < 400);
				o_valid <= 1'b0;
				o_data <= ~o_data;
			end else if (!o_valid || i_conv_ready) begin
				// released lines show garbage, never the last word
				o_valid <= 1'b0;
				o_data <= ~o_data;
			end
		end
	end
endmodule : conv_model

// File: testbench/tb_top.sv
// self-checking bench for the output data register block
// assumes the conversion gap is shortened to 8 cycles
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, men = 1'b0, big = 1'b0, fast = 1'b0;
	logic rd_en = 1'b0, rd_first = 1'b0, burst = 1'b0, slow = 1'b0, flood = 1'b0, fl = 1'b0;
	logic [7:0] rd_addr = 8'h00, ptr = 8'h00, temp = 8'h00;
	logic [11:0] vmag = 12'h000, mag = 12'h000;
	logic [11:0] ax [3] = '{default: 12'h000};
	logic [47:0] set = 48'h0;
	logic req, cvalid, cready, rvalid, flag;
	logic [1:0] rchan, cchan;
	logic [11:0] cdata;
	logic [7:0] rdata, raddr;
	int fails = 0, check_count = 0;
	always #4 clk = ~clk;
	accel_output_data_regs #(.CONV_GAP_CYCLES(8)) uut (.i_core_clk(clk), .i_arst_n(rst_n),
		.i_odr_tick(tick), .i_magnitude_enable(men), .i_byte_order_select(big),
		.i_fast_read(fast), .o_conv_req(req), .o_conv_chan(rchan), .i_conv_valid(cvalid),
		.o_conv_ready(cready), .i_conv_chan(cchan), .i_conv_data(cdata),
		.i_vector_magnitude(vmag), .i_rd_en(rd_en), .i_rd_first(rd_first),
		.i_rd_addr(rd_addr), .i_burst_active(burst), .o_rd_valid(rvalid),
		.o_rd_data(rdata), .o_rd_addr(raddr), .o_data_ready_flag(flag));
	conv_model partner (.i_core_clk(clk), .i_conv_req(req), .i_conv_chan(rchan),
		.i_conv_ready(cready), .i_set(set), .i_slow(slow), .i_flood(flood),
		.o_valid(cvalid), .o_chan(cchan), .o_data(cdata));
	task automatic tally_and_finish;
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] exp_byte(input logic [7:0] a);
		logic [11:0] s;
		logic b;
		b = big || (fast && a > 8'h03);
		s = (a < 8'h04) ? mag : ax[a[2:1] - 2'h2];
		if (a == 8'h01)
			return temp;
		if (a < 8'h02 || a > 8'h09)
			return 8'h00;
		if (!a[0])
			return b ? s[11:4] : s[7:0];
		return b ? {s[3:0], 4'h0} : (a == 8'h03 ? {4'h0, s[11:8]} : {{4{s[11]}}, s[11:8]});
	endfunction : exp_byte
	task automatic rd(input logic f, input logic [7:0] a);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_first <= f;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		if (f)
			ptr = a;
		if (ptr > 8'h01 && ptr < 8'h0a)
			fl = 1'b0;
		chk(8'(rvalid), 8'h01);
		chk(raddr, ptr);
		chk(rdata, exp_byte(ptr));
		chk(8'(flag), 8'(fl));
		ptr = (fast && ptr inside {8'h04, 8'h06, 8'h08}) ? ptr + 8'h02 : ptr + 8'h01;
	endtask : rd
	task automatic start_set(input logic en);
		@(posedge clk);
		set[47:16] <= $urandom();
		set[15:0] <= 16'($urandom());
		vmag <= 12'($urandom());
		slow <= 1'($urandom());
		men <= en;
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
	endtask : start_set
	task automatic wait_flag;
		int n;
		n = 0;
		while (flag !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 400) begin
				fails++;
				tally_and_finish();
			end
		end
		temp = set[7:0];
		for (int i = 0; i < 3; i++)
			ax[i] = set[12*i+12 +: 12];
		if (men)
			mag = vmag;
		fl = 1'b1;
	endtask : wait_flag
	initial begin
		void'($urandom(28108));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 1; a < 11; a++)
			rd(1'b1, 8'(a));
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			big <= (m == 1);
			fast <= (m == 2);
			start_set(m != 1);
			wait_flag();
			burst <= 1'b1;
			rd(1'b1, (m == 2) ? 8'h04 : 8'h01);
			for (int k = 0; k < ((m == 2) ? 3 : 9); k++)
				rd(1'b0, 8'h00);
			burst <= 1'b0;
		end
		// completed set held back by a burst while the fifo fills
		@(posedge clk);
		burst <= 1'b1;
		start_set(1'b1);
		repeat (60) @(posedge clk);
		flood <= 1'b1;
		repeat (40) @(posedge clk);
		#1;
		chk(8'(flag), 8'h00);
		chk(8'(cready), 8'h00);
		rd(1'b1, 8'h05);
		flood <= 1'b0;
		burst <= 1'b0;
		wait_flag();
		rd(1'b1, 8'h04);
		repeat (40) @(posedge clk);
		#1;
		chk(8'(cready), 8'h01);
		tally_and_finish();
	end
endmodule : tb_top
